// >>> cal_consts.svh
// constants for the select-to-command latency link
// assumes inclusion by bare name from each end and the package
`ifndef CAL_CONSTS_SVH
`define CAL_CONSTS_SVH
`define CMD_W 3
`define ADDR_W 18
`define CAL_W 3
`define CAL_MAX 8
`define CMD_DESELECT 3'h0
`define CMD_MODE_WRITE 3'h1
`define CMD_ACTIVATE 3'h2
`define CMD_READ 3'h3
`define CMD_WRITE 3'h4
`define CMD_PRECHARGE 3'h5
`define CMD_REFRESH 3'h6
`define MR_SEL_ONE 2'h1
`define MR_SEL_LSB 16
`define CAL_FIELD_LSB 0
`define CAL_ON_BIT 3
`define SETTLE_CYCLES 8'h18
`define REPEAT_CYCLES 8'h08
`define RX_HOLD_CYCLES 4'h2
`endif

// >>> cal_pkg.sv
// types shared by both ends of the latency link
// assumes cal_consts.svh sits in the include path
`include "cal_consts.svh"
package cal_pkg;
  typedef logic [`CMD_W-1:0] cmd_t;
  typedef logic [`ADDR_W-1:0] addr_t;
  typedef logic [`CAL_W-1:0] cal_t;
endpackage

// >>> cal_link_if.sv
// command/address link between controller and device
// assumes both ends run on the same REF_CLK
interface cal_link_if;
  logic cs_b;
  cal_pkg::cmd_t cmd;
  cal_pkg::addr_t addr;
  logic on_die_termination_control;
  modport ctrl (output cs_b, output cmd, output addr, output on_die_termination_control);
  modport dev (input cs_b, input cmd, input addr, input on_die_termination_control);
endinterface

// >>> cal_device.sv
// device end: registers command/address a programmed latency after select
// assumes controller keeps spacing and programs latency in whole cycles
//
// How it works
// R1 - command taken exactly latency cycles after select
// R2 - mode write to register one sets latency enable and value
// R3 - controller programs latency in whole clock cycles
// R4 - receivers woken by select, slept after latch
// R5 - receivers stay awake across back-to-back commands
// R6 - controller waits settle plus latency before commands
// R7 - controller spaces mode writes settle plus latency
// R8 - gaps use newly programmed latency value
// R9 - termination control timing ignores latency
// R10 - latency off: command taken with select
`include "cal_consts.svh"
module cal_device
  import cal_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_B,
  // link
  cal_link_if.dev LINK,
  // decoded command out
  output logic CMD_VALID,
  output cal_pkg::cmd_t CMD,
  output cal_pkg::addr_t ADDR,
  output logic ODT_LEVEL,
  // state
  output logic CAL_ON,
  output cal_pkg::cal_t CAL_CYCLES,
  output logic RX_AWAKE
);
  import cal_pkg::*;

  // ==========================================================
  // state and next values
  logic [`CAL_MAX-1:0] sel_hist_q;
  logic [`CAL_MAX-1:0] sel_hist_d;
  logic cal_on_q;
  logic cal_on_d;
  cal_t cal_q;
  cal_t cal_d;
  logic [3:0] rx_hold_q;
  logic [3:0] rx_hold_d;
  logic valid_q;
  logic valid_d;
  cmd_t cmd_q;
  cmd_t cmd_d;
  addr_t addr_q;
  addr_t addr_d;
  logic odt_q;
  logic odt_d;

  // ==========================================================
  // decode helpers
  // mode register one is picked by the upper address pair
  function automatic logic mr_one_hit(input cmd_t c, input addr_t a);
    mr_one_hit = (c == `CMD_MODE_WRITE) && (a[`MR_SEL_LSB +: 2] == `MR_SEL_ONE);
  endfunction

  // a zero latency behaves like latency off for wake-up purposes
  function automatic logic lat_active(input logic on, input cal_t l);
    lat_active = on && (l != '0);
  endfunction

  // ==========================================================
  // select history
  wire logic sel_now = ~LINK.cs_b;
  wire logic [`CAL_MAX:0] sel_line = {sel_hist_q, sel_now};
  // the command belonging to a select seen cal cycles ago
  wire logic take = cal_on_q ? sel_line[cal_q] : sel_now; // [R1] [R10]
  wire logic is_mr1 = mr_one_hit(LINK.cmd, LINK.addr);
  wire logic sel_pending = |sel_line;
  wire logic delayed = lat_active(cal_on_q, cal_q);

  assign sel_hist_d = sel_line[`CAL_MAX-1:0];

  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      sel_hist_q <= '0;
    end else begin
      sel_hist_q <= sel_hist_d;
    end
  end

  // ==========================================================
  // mode register one: latency enable and value
  // loaded on the capture edge, so the write itself uses the old latency
  wire logic mr_load = take && is_mr1;

  assign cal_on_d = mr_load ? LINK.addr[`CAL_ON_BIT] : cal_on_q; // [R2]
  assign cal_d = mr_load ? LINK.addr[`CAL_FIELD_LSB +: `CAL_W] : cal_q; // [R8]

  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      cal_on_q <= 1'b0;
    end else begin
      cal_on_q <= cal_on_d;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      cal_q <= '0;
    end else begin
      cal_q <= cal_d;
    end
  end

  // ==========================================================
  // receiver power: on from select until two cycles after it leaves the select history
  wire logic hold_left = rx_hold_q != 4'h0;
  wire logic hold_more = sel_pending || hold_left;

  // any select still in the pipe re-arms the hold, covering command runs
  assign rx_hold_d = sel_pending ? `RX_HOLD_CYCLES : (hold_left ? rx_hold_q - 4'h1 : rx_hold_q); // [R4] [R5]

  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      rx_hold_q <= 4'h0;
    end else begin
      rx_hold_q <= rx_hold_d;
    end
  end

  // zero latency leaves no time to wake, so receivers stay on
  assign RX_AWAKE = !delayed || hold_more; // [R4]

  // ==========================================================
  // captured command; termination sampled undelayed
  assign valid_d = take;
  assign cmd_d = take ? LINK.cmd : `CMD_DESELECT;
  assign addr_d = take ? LINK.addr : addr_q;
  // termination never rides the latency pipe
  assign odt_d = LINK.on_die_termination_control; // [R9]

  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= valid_d;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      cmd_q <= `CMD_DESELECT;
    end else begin
      cmd_q <= cmd_d;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      addr_q <= '0;
    end else begin
      addr_q <= addr_d;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      odt_q <= 1'b0;
    end else begin
      odt_q <= odt_d;
    end
  end

  // ==========================================================
  // outputs
  assign CMD_VALID = valid_q;
  assign CMD = cmd_q;
  assign ADDR = addr_q;
  assign ODT_LEVEL = odt_q;
  assign CAL_ON = cal_on_q;
  assign CAL_CYCLES = cal_q;
endmodule // cal_device

// >>> cal_ctrl.sv
// controller end: places select, then command after latency
// assumes one request at a time, accepted when REQ_READY
`include "cal_consts.svh"
module cal_ctrl
  import cal_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_B,
  // user request
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire cal_pkg::cmd_t REQ_CMD,
  input wire cal_pkg::addr_t REQ_ADDR,
  input wire logic ODT_REQ,
  // link
  cal_link_if.ctrl LINK
);
  import cal_pkg::*;

  typedef enum logic [1:0] {IDLE, WAIT_CMD, GAP} st_e;
  st_e st_q;
  logic [7:0] cnt_q;
  logic [7:0] gap_q;
  logic cal_on_q;
  cal_t cal_q;
  cmd_t cmd_q;
  addr_t addr_q;
  logic cs_b_q;
  cmd_t lcmd_q;
  addr_t laddr_q;
  logic odt_q;

  wire logic accept = st_q == IDLE && REQ_VALID;
  wire logic is_mr1 = REQ_CMD == `CMD_MODE_WRITE &&
    REQ_ADDR[`MR_SEL_LSB +: 2] == `MR_SEL_ONE;
  // new value used once written, old enable covers "being disabled" too
  wire logic next_on = is_mr1 ? REQ_ADDR[`CAL_ON_BIT] : cal_on_q;
  wire cal_t next_cal = is_mr1 ? REQ_ADDR[`CAL_FIELD_LSB +: `CAL_W] : cal_q; // [R3] [R8]
  wire logic ext = cal_on_q || next_on;
  // one gap covers both next-command and next-mode-write spacing
  wire logic [7:0] mr_gap = ext ? `SETTLE_CYCLES + {5'h0, next_cal} : `SETTLE_CYCLES; // [R6] [R7]
  wire logic [7:0] gap_for = REQ_CMD == `CMD_MODE_WRITE ? mr_gap : 8'h00;
  wire logic cmd_due = (st_q == WAIT_CMD && cnt_q == 8'h00);

  assign REQ_READY = st_q == IDLE;

  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      st_q <= IDLE;
      cnt_q <= 8'h00;
      gap_q <= 8'h00;
      cal_on_q <= 1'b0;
      cal_q <= '0;
      cmd_q <= `CMD_DESELECT;
      addr_q <= '0;
    end else begin
      unique case (st_q)
        IDLE: if (accept) begin
          cmd_q <= REQ_CMD;
          addr_q <= REQ_ADDR;
          gap_q <= gap_for;
          cnt_q <= cal_on_q ? {5'h0, cal_q} - 8'h01 : 8'h00; // [R1]
          st_q <= (cal_on_q && cal_q != '0) ? WAIT_CMD : (gap_for != 8'h00 ? GAP : IDLE);
          if (is_mr1) begin
            cal_on_q <= next_on;
            cal_q <= next_cal;
          end
        end
        WAIT_CMD: if (cnt_q == 8'h00) begin
          cnt_q <= gap_q;
          st_q <= gap_q != 8'h00 ? GAP : IDLE;
        end else begin
          cnt_q <= cnt_q - 8'h01;
        end
        GAP: if (cnt_q <= 8'h01) begin
          st_q <= IDLE;
        end else begin
          cnt_q <= cnt_q - 8'h01;
        end
        default: st_q <= IDLE;
      endcase
      if (accept && !(cal_on_q && cal_q != '0)) begin
        cnt_q <= gap_for;
      end
    end
  end

  // ==========================================================
  // pins registered; command rides with select or latency later
  wire logic now_cmd = accept && !(cal_on_q && cal_q != '0);
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      cs_b_q <= 1'b1;
      lcmd_q <= `CMD_DESELECT;
      laddr_q <= '0;
      odt_q <= 1'b0;
    end else begin
      cs_b_q <= !accept;
      lcmd_q <= now_cmd ? REQ_CMD : (cmd_due ? cmd_q : `CMD_DESELECT); // [R1] [R10]
      laddr_q <= now_cmd ? REQ_ADDR : (cmd_due ? addr_q : laddr_q);
      odt_q <= ODT_REQ; // [R9]
    end
  end

  assign LINK.cs_b = cs_b_q;
  assign LINK.cmd = lcmd_q;
  assign LINK.addr = laddr_q;
  assign LINK.on_die_termination_control = odt_q;
endmodule // cal_ctrl

// >>> cal_link_properties.sv
// checker: timing on the link between controller and device
// assumes it sits beside the link and sees every edge of REF_CLK
`include "cal_consts.svh"
module cal_link_properties
  import cal_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_B,
  // link
  input wire logic cs_b,
  input wire cal_pkg::cmd_t cmd,
  input wire cal_pkg::addr_t addr,
  input wire logic on_die_termination_control
);
  import cal_pkg::*;
  // ====
  // shadow of the latency setting
  logic on_q;
  cal_t lat_q;
  logic [8:0] sel_q;
  logic [5:0] gap_q;
  logic seen_q;
  wire mode_wr = cmd == `CMD_MODE_WRITE && addr[`MR_SEL_LSB+:2] == `MR_SEL_ONE;
  wire lat_on = on_q && lat_q != 3'h0;
  wire busy = cmd != `CMD_DESELECT;
  wire [7:0] need = `SETTLE_CYCLES + {5'h0, lat_q};
  wire [7:0] gap = {2'h0, gap_q};
  // gap saturates, so long idle never wraps into a false short gap
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      on_q <= 1'b0;
      lat_q <= 3'h0;
      sel_q <= 9'h0;
      gap_q <= 6'h0;
      seen_q <= 1'b0;
    end else begin
      sel_q <= {sel_q[7:0], !cs_b};
      gap_q <= mode_wr ? 6'h1 : gap_q + {5'h0, gap_q != 6'h3f};
      if (mode_wr) begin
        on_q <= addr[`CAL_ON_BIT];
        lat_q <= addr[`CAL_FIELD_LSB +: `CAL_W];
        seen_q <= 1'b1;
      end
    end
  end
  // ====
  // properties
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  sequence s_sel;
    !cs_b ##1 cs_b;
  endsequence
  property p_cmd_after_sel; lat_on && busy |-> sel_q[lat_q - 3'h1]; endproperty
  property p_quiet_after_sel; lat_on && lat_q > 3'h1 && !cs_b |=> !busy; endproperty
  property p_off_cmd; !lat_on && busy |-> !cs_b; endproperty
  property p_off_sel; !lat_on && !cs_b |-> busy; endproperty
  property p_sel_single; $fell(cs_b) |-> s_sel; endproperty
  property p_settle; !cs_b && seen_q |-> gap >= `SETTLE_CYCLES; endproperty
  property p_repeat; mode_wr && seen_q && on_q |-> gap >= need; endproperty
  property p_new_lat; !cs_b && seen_q && on_q |-> gap >= need; endproperty
  a_cmd_after_sel: assert property (p_cmd_after_sel) else $error("command off latency");
  a_quiet_after_sel: assert property (p_quiet_after_sel) else $error("early command");
  a_off_cmd: assert property (p_off_cmd) else $error("command without select");
  a_off_sel: assert property (p_off_sel) else $error("select without command");
  a_sel_single: assert property (p_sel_single) else $error("select too long");
  a_settle: assert property (p_settle) else $error("select too soon");
  a_repeat: assert property (p_repeat) else $error("mode write too soon");
  a_new_lat: assert property (p_new_lat) else $error("gap ignores latency");
endmodule // cal_link_properties

// >>> cs_to_command_latency_tb.sv
// testbench: controller and device joined by the link
// assumes design files and cal_consts.svh are compiled first
`include "cal_consts.svh"
module cs_to_command_latency_tb
  import cal_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  // stimulus and wiring
  logic REF_CLK = 1'b0;
  logic RST_B = 1'b0;
  logic REQ_VALID = 1'b0;
  logic ODT_REQ = 1'b0;
  cmd_t REQ_CMD = 3'h0;
  addr_t REQ_ADDR = 18'h0;
  logic REQ_READY, CMD_VALID, ODT_LEVEL, CAL_ON, RX_AWAKE;
  cmd_t CMD;
  addr_t ADDR;
  cal_t CAL_CYCLES;
  int err_count = 0;
  int n_checks = 0;
  int cur = 0;
  logic [3:0] modes [5] = '{4'hb, 4'hf, 4'h8, 4'h9, 4'h3};
  always #2 REF_CLK = ~REF_CLK;
  cal_link_if cal_link_if_i ();
  cal_ctrl cal_ctrl_i (.REF_CLK(REF_CLK), .RST_B(RST_B), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY),
    .REQ_CMD(REQ_CMD), .REQ_ADDR(REQ_ADDR), .ODT_REQ(ODT_REQ), .LINK(cal_link_if_i.ctrl));
  cal_device cal_device_i (.REF_CLK(REF_CLK), .RST_B(RST_B), .LINK(cal_link_if_i.dev), .CMD_VALID(CMD_VALID),
    .CMD(CMD), .ADDR(ADDR), .ODT_LEVEL(ODT_LEVEL), .CAL_ON(CAL_ON), .CAL_CYCLES(CAL_CYCLES), .RX_AWAKE(RX_AWAKE));
  cal_link_properties cal_link_properties_i (.REF_CLK(REF_CLK), .RST_B(RST_B), .cs_b(cal_link_if_i.cs_b),
    .cmd(cal_link_if_i.cmd), .addr(cal_link_if_i.addr), .on_die_termination_control(cal_link_if_i.on_die_termination_control));
  // ====
  // tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // counts falling edges until ready, or captured command when done is set
  task automatic wait_for(input bit done, output int n);
    n = 0;
    do begin
      @(negedge REF_CLK);
      n++;
    end while ((done ? CMD_VALID : REQ_READY) !== 1'b1 && n < 200);
    if (n >= 200) begin
      err_count++;
      give_verdict();
    end
  endtask
  task automatic send(input cmd_t c, input addr_t a);
    int n;
    REQ_CMD <= c;
    REQ_ADDR <= a;
    REQ_VALID <= 1'b1;
    wait_for(1'b0, n);
    @(posedge REF_CLK);
    REQ_VALID <= 1'b0;
    wait_for(1'b1, n);
    chk(n, 2 + cur, "delay");
    chk(CMD, c, "cmd");
    chk(ADDR, a, "addr");
    chk(RX_AWAKE, 1'b1, "rx");
    @(posedge REF_CLK);
  endtask
  task automatic mwr(input logic on, input cal_t l);
    int n;
    send(`CMD_MODE_WRITE, {`MR_SEL_ONE, 12'h0, on, l});
    cur = on ? int'(l) : 0;
    @(negedge REF_CLK);
    chk(CAL_ON, on, "on");
    chk(CAL_CYCLES, l, "cycles");
    wait_for(1'b0, n);
    chk(RX_AWAKE, !(on && l != 3'h0), "rx idle");
    @(posedge REF_CLK);
  endtask
  // ====
  // sequence
  initial begin
    repeat (8) @(posedge REF_CLK);
    RST_B <= 1'b1;
    @(negedge REF_CLK);
    chk(CAL_ON, 1'b0, "reset on");
    chk(RX_AWAKE, 1'b1, "reset rx");
    @(posedge REF_CLK);
    // a write to another mode register must leave the latency alone
    send(`CMD_MODE_WRITE, {2'h2, 12'h0, 1'b1, 3'h5});
    @(negedge REF_CLK);
    chk(CAL_ON, 1'b0, "other reg");
    @(posedge REF_CLK);
    for (int i = 0; i < 5; i++) begin
      mwr(modes[i][3], modes[i][2:0]);
      if (i == 1) begin
        ODT_REQ <= 1'b1;
        repeat (2) @(posedge REF_CLK);
        @(negedge REF_CLK);
        chk(ODT_LEVEL, 1'b1, "odt");
        @(posedge REF_CLK);
        ODT_REQ <= 1'b0;
      end
      for (int k = 2; k <= 6; k++) begin
        send(k[2:0], {k[2:0], i[2:0], 12'ha5c});
      end
    end
    give_verdict();
  end
endmodule // cs_to_command_latency_tb
